/* File: hw/psm_ctrl.sv */
// Power-saving mode sequencer: RUN, WAIT and STOP with wake and resume control.
// Assumes the core issues one-cycle instruction strobes and tracks its own context;
// all inputs except rst_i and nmi_pin_i are synchronous to core_clk_i; nmi_pin_i is synchronised.
//
// Function
// R1: After any reset come up in RUN with CPU and oscillator clocked.
// R2: WAIT halts the CPU at once; active oscillator keeps running.
// R3: RAM and peripheral registers hold their values in WAIT and STOP.
// R4: WAIT ends on reset, peripheral interrupt or external interrupt including NMI.
// R5: STOP halts the CPU and stops the oscillator.
// R6: STOP ends on reset, externally clocked peripheral or external interrupt.
// R7: Every STOP exit waits 2048 internal clocks before vectoring.
// R8: Watchdog active turns STOP into WAIT unless option set and NMI pin high.
// R9: With global enable clear, NMI does not wake from WAIT or STOP.
// R10: From main program, waking interrupt is serviced then next instruction runs.
// R11: From NMI routine, resume at next instruction, staying in NMI context.
// R12: From interrupt routine woken by maskable, resume next instruction in context.
// R13: From interrupt routine woken by NMI, service NMI first then resume.
// R14: WAIT and STOP are ignored while an enabled request is pending.
// R15: Software enables the auxiliary oscillator before WAIT if it wants it.
// R16: Software powers peripherals down before STOP to save current.
// R17: External interrupts wake from STOP only with global enable set.
// R18: Clearing global enable, bit 4 of option register, masks maskable sources.
// R19: Stabilisation delay counts internal clocks from restart; CPU released at end.
// R20: Reset during WAIT or STOP returns to RUN through the reset sequence.
module psm_ctrl
	import psm_pkg::*;
#(
	parameter int unsigned NUM_PIRQ     = PSM_NUM_PIRQ,
	parameter int unsigned START_CYCLES = PSM_OSC_START_CYCLES
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wait_instr_i,
	input  wire logic                  stop_instr_i,
	input  wire psm_ctx_t              core_ctx_i,
	input  wire logic [PSM_IOR_W-1:0]  interrupt_option_reg_i,
	input  wire logic                  low_freq_aux_osc_i,
	input  wire logic                  watchdog_active_i,
	input  wire logic                  stop_external_control_opt_i,
	input  wire logic                  nmi_pin_i,
	input  wire logic                  nmi_req_i,
	input  wire logic                  ext_irq_i,
	input  wire logic [NUM_PIRQ-1:0]   periph_irq_i,
	input  wire logic [NUM_PIRQ-1:0]   periph_ext_clk_i,
	output psm_mode_t                  mode_o,
	output logic                       cpu_clk_en_o,
	output logic                       periph_clk_en_o,
	output logic                       main_osc_en_o,
	output logic                       aux_osc_en_o,
	output logic                       watchdog_freeze_o,
	output psm_resume_cmd_t            resume_o
);

	typedef enum logic [2:0] {
		PSM_ST_RUN,
		PSM_ST_WAIT,
		PSM_ST_STOP,
		PSM_ST_OSC_START,
		PSM_ST_RESUME
	} psm_state_t;

	psm_state_t      state;
	psm_state_t      next_state;
	psm_ctx_t        entry_ctx;
	psm_ctx_t        next_entry_ctx;
	logic            woke_nmi;
	logic            next_woke_nmi;
	logic            use_aux;
	logic            next_use_aux;
	psm_mode_t       next_mode;
	logic            next_cpu_clk_en;
	logic            next_periph_clk_en;
	logic            next_main_osc_en;
	logic            next_aux_osc_en;
	logic            next_wd_freeze;
	psm_resume_cmd_t next_resume;
	logic            nmi_pin_meta;
	logic            nmi_pin_sync;
	logic            osc_start;
	logic            osc_busy;
	logic            osc_done;
	logic            gen;
	psm_wake_t       wake;

	function automatic psm_resume_t resume_kind(input psm_ctx_t ctx, input logic by_nmi);
		psm_resume_t k;
		k = PSM_RES_SERVICE;
		if (ctx == PSM_CTX_NMI) begin
			k = PSM_RES_NEXT; // [R11]
		end else if (ctx == PSM_CTX_IRQ) begin
			k = by_nmi ? PSM_RES_NMI_FIRST : PSM_RES_NEXT; // [R12] [R13]
		end
		return k;
	endfunction

	assign gen = interrupt_option_reg_i[PSM_GEN_BIT]; // [R18]

	psm_wake_qual #(
		.NUM_PIRQ (NUM_PIRQ)
	) u_wake (
		.global_irq_enable_i (gen),
		.nmi_req_i           (nmi_req_i),
		.ext_irq_i           (ext_irq_i),
		.periph_irq_i        (periph_irq_i),
		.periph_ext_clk_i    (periph_ext_clk_i),
		.wake_o              (wake)
	);

	psm_osc_timer #(
		.START_CYCLES (START_CYCLES)
	) u_osc (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.start_i    (osc_start),
		.busy_o     (osc_busy),
		.done_o     (osc_done)
	);

	// NMI pin is asynchronous; only the second stage is read
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nmi_pin_meta <= 1'b0;
			nmi_pin_sync <= 1'b0;
		end else begin
			nmi_pin_meta <= nmi_pin_i;
			nmi_pin_sync <= nmi_pin_meta;
		end
	end

	always_comb begin
		next_state         = state;
		next_entry_ctx     = entry_ctx;
		next_woke_nmi      = woke_nmi;
		next_use_aux       = use_aux;
		osc_start          = 1'b0;
		next_resume        = '{valid: 1'b0, kind: PSM_RES_NONE};
		case (state)
			PSM_ST_RUN: begin
				// A pending enabled request turns the instruction into a no-op
				if ((wait_instr_i | stop_instr_i) && !wake.pending) begin // [R14]
					next_entry_ctx = core_ctx_i;
					next_use_aux   = low_freq_aux_osc_i; // [R15]
					if (stop_instr_i && (!watchdog_active_i
						|| (stop_external_control_opt_i && nmi_pin_sync))) begin
						next_state = PSM_ST_STOP; // [R5] [R8]
					end else begin
						next_state = PSM_ST_WAIT; // [R2] [R8]
					end
				end
			end
			PSM_ST_WAIT: begin
				if (wake.wake_wait) begin // [R4] [R9]
					next_woke_nmi = wake.nmi;
					next_state    = PSM_ST_RESUME;
				end
			end
			PSM_ST_STOP: begin
				if (wake.wake_stop) begin // [R6] [R9] [R17]
					next_woke_nmi = wake.nmi;
					osc_start     = 1'b1; // [R7] [R19]
					next_state    = PSM_ST_OSC_START;
				end
			end
			PSM_ST_OSC_START: begin
				if (osc_done) begin // [R7] [R19]
					next_state = PSM_ST_RESUME;
				end
			end
			PSM_ST_RESUME: begin
				next_resume = '{valid: 1'b1, kind: resume_kind(entry_ctx, woke_nmi)}; // [R10]
				next_state  = PSM_ST_RUN;
			end
			default: begin
				next_state = PSM_ST_RUN;
			end
		endcase
	end

	// Output decode from the next state so every output is a flop
	always_comb begin
		next_mode          = PSM_MODE_RUN;
		next_cpu_clk_en    = 1'b0;
		next_periph_clk_en = 1'b1;
		next_main_osc_en   = 1'b1;
		next_aux_osc_en    = next_use_aux;
		next_wd_freeze     = 1'b0;
		case (next_state)
			PSM_ST_RUN: begin
				next_cpu_clk_en = 1'b1; // [R1]
				next_aux_osc_en = 1'b0;
			end
			PSM_ST_WAIT: begin
				next_mode        = PSM_MODE_WAIT; // [R2] [R3]
				next_main_osc_en = !next_use_aux;
			end
			PSM_ST_STOP: begin
				next_mode          = PSM_MODE_STOP; // [R5] [R3]
				next_periph_clk_en = 1'b0;
				next_main_osc_en   = 1'b0;
				next_aux_osc_en    = 1'b0;
				next_wd_freeze     = watchdog_active_i; // [R8]
			end
			PSM_ST_OSC_START: begin
				next_mode          = PSM_MODE_STOP;
				next_periph_clk_en = 1'b0; // Held until oscillator settles
				next_aux_osc_en    = 1'b0;
				next_wd_freeze     = watchdog_freeze_o;
			end
			default: begin
				next_mode       = mode_o;
				next_aux_osc_en = aux_osc_en_o;
				next_main_osc_en = main_osc_en_o;
			end
		endcase
	end

	// Reset from any source lands here, forcing RUN and the reset vector path
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state             <= PSM_ST_RUN; // [R1] [R20]
			entry_ctx         <= PSM_CTX_MAIN;
			woke_nmi          <= 1'b0;
			use_aux           <= 1'b0;
			mode_o            <= PSM_MODE_RUN;
			cpu_clk_en_o      <= 1'b1;
			periph_clk_en_o   <= 1'b1;
			main_osc_en_o     <= 1'b1;
			aux_osc_en_o      <= 1'b0;
			watchdog_freeze_o <= 1'b0;
			resume_o          <= '{valid: 1'b0, kind: PSM_RES_NONE};
		end else begin
			state             <= next_state;
			entry_ctx         <= next_entry_ctx;
			woke_nmi          <= next_woke_nmi;
			use_aux           <= next_use_aux;
			mode_o            <= next_mode;
			cpu_clk_en_o      <= next_cpu_clk_en;
			periph_clk_en_o   <= next_periph_clk_en;
			main_osc_en_o     <= next_main_osc_en;
			aux_osc_en_o      <= next_aux_osc_en;
			watchdog_freeze_o <= next_wd_freeze;
			resume_o          <= next_resume;
		end
	end

	sequence s_stop_woken;
		state == PSM_ST_STOP && wake.wake_stop;
	endsequence

	sequence s_resume_out;
		resume_o.valid && cpu_clk_en_o;
	endsequence

	// Cycles from a STOP wake to the resume pulse; a counter keeps the check cheap for 2048
	logic               exit_trk;
	logic               next_exit_trk;
	logic [PSM_CNT_W:0] exit_cnt;
	logic [PSM_CNT_W:0] next_exit_cnt;

	always_comb begin
		next_exit_trk = exit_trk;
		next_exit_cnt = exit_cnt;
		if (state == PSM_ST_STOP && wake.wake_stop) begin
			next_exit_trk = 1'b1;
			next_exit_cnt = '0;
		end else if (resume_o.valid) begin
			next_exit_trk = 1'b0;
		end else if (exit_trk) begin
			next_exit_cnt = exit_cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			exit_trk <= 1'b0;
			exit_cnt <= '0;
		end else begin
			exit_trk <= next_exit_trk;
			exit_cnt <= next_exit_cnt;
		end
	end

	a_reset_run_mode: assert property (@(posedge core_clk_i) // [R1]
		$fell(rst_i) |-> mode_o == PSM_MODE_RUN && cpu_clk_en_o)
		else $error("not in run after reset");

	a_wait_halts_cpu: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R2]
		mode_o == PSM_MODE_WAIT |-> !cpu_clk_en_o && periph_clk_en_o
			&& (main_osc_en_o || aux_osc_en_o))
		else $error("wait clocks wrong");

	a_stop_osc_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R5]
		state == PSM_ST_STOP |-> !main_osc_en_o && !cpu_clk_en_o)
		else $error("oscillator running in stop");

	a_wait_wake_two: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R4]
		state == PSM_ST_WAIT && wake.wake_wait |-> ##2 resume_o.valid)
		else $error("wait wake not resumed");

	a_stop_delay_min: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R7]
		s_stop_woken |-> !resume_o.valid [*8])
		else $error("stop exit too early");

	a_stop_delay_max: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R19]
		exit_trk && resume_o.valid |-> exit_cnt == (PSM_CNT_W+1)'(START_CYCLES + 2)
			##0 s_resume_out)
		else $error("stop exit time wrong");

	a_wd_stop_wait: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R8]
		state == PSM_ST_RUN && stop_instr_i && !wake.pending && watchdog_active_i
			&& !(stop_external_control_opt_i && nmi_pin_sync)
		|=> state == PSM_ST_WAIT)
		else $error("stop not replaced by wait");

	a_gen_blocks_nmi: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R9]
		state == PSM_ST_WAIT && !gen |=> state == PSM_ST_WAIT)
		else $error("wake with global enable clear");

	a_pending_no_op: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R14]
		state == PSM_ST_RUN && wake.pending |=> state == PSM_ST_RUN)
		else $error("low power entered while pending");

	a_nmi_ctx_next: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R11]
		resume_o.valid && $past(entry_ctx) == PSM_CTX_NMI |-> resume_o.kind == PSM_RES_NEXT)
		else $error("nmi context resume wrong");

endmodule

/* File: inc/psm_pkg.sv */
// Power-mode sequencer package: modes, contexts, carriers and timing constants.
// Assumes a single 200 MHz core clock and an active-high asynchronous reset.
package psm_pkg;

	localparam int unsigned PSM_OSC_START_CYCLES = 2048;
	localparam int unsigned PSM_CNT_W            = 12;
	localparam int unsigned PSM_GEN_BIT          = 4;
	localparam int unsigned PSM_IOR_W            = 8;
	localparam int unsigned PSM_NUM_PIRQ         = 4;

	typedef enum logic [1:0] {
		PSM_MODE_RUN,
		PSM_MODE_WAIT,
		PSM_MODE_STOP
	} psm_mode_t;

	typedef enum logic [1:0] {
		PSM_CTX_MAIN,
		PSM_CTX_IRQ,
		PSM_CTX_NMI
	} psm_ctx_t;

	typedef enum logic [1:0] {
		PSM_RES_NONE,
		PSM_RES_SERVICE,
		PSM_RES_NEXT,
		PSM_RES_NMI_FIRST
	} psm_resume_t;

	// Wake request summary handed from the qualifier to the sequencer
	typedef struct packed {
		logic wake_wait;
		logic wake_stop;
		logic nmi;
		logic maskable;
		logic pending;
	} psm_wake_t;

	// Resume directive handed to the core
	typedef struct packed {
		logic        valid;
		psm_resume_t kind;
	} psm_resume_cmd_t;

endpackage

/* File: hw/psm_wake_qual.sv */
// Wake qualifier: sorts interrupt requests into wake causes for WAIT and STOP.
// Assumes request inputs are already synchronous to core_clk_i.
module psm_wake_qual
	import psm_pkg::*;
#(
	parameter int unsigned NUM_PIRQ = PSM_NUM_PIRQ
) (
	input  wire logic                 global_irq_enable_i,
	input  wire logic                 nmi_req_i,
	input  wire logic                 ext_irq_i,
	input  wire logic [NUM_PIRQ-1:0]  periph_irq_i,
	input  wire logic [NUM_PIRQ-1:0]  periph_ext_clk_i,
	output psm_wake_t                 wake_o
);

	logic periph_any;
	logic periph_stop;

	always_comb begin
		// Masking by global enable covers every maskable source [R18]
		periph_any  = global_irq_enable_i & (|periph_irq_i);
		// Only externally clocked peripherals can still signal in STOP [R6]
		periph_stop = global_irq_enable_i & (|(periph_irq_i & periph_ext_clk_i));
		wake_o.maskable  = periph_any | (global_irq_enable_i & ext_irq_i); // [R17]
		// NMI is ignored for wake while global enable is clear [R9]
		wake_o.nmi       = global_irq_enable_i & nmi_req_i;
		wake_o.wake_wait = wake_o.maskable | wake_o.nmi; // [R4]
		wake_o.wake_stop = periph_stop | (global_irq_enable_i & ext_irq_i)
			| wake_o.nmi; // [R6]
		wake_o.pending   = wake_o.maskable | nmi_req_i;
	end

endmodule

/* File: hw/psm_osc_timer.sv */
// Oscillator start-up timer: counts internal clock cycles after restart.
// Assumes start_i is a single-cycle pulse issued when the oscillator is re-enabled.
module psm_osc_timer
	import psm_pkg::*;
#(
	parameter int unsigned START_CYCLES = PSM_OSC_START_CYCLES
) (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic start_i,
	output logic      busy_o,
	output logic      done_o
);

	logic [PSM_CNT_W:0] count;
	logic [PSM_CNT_W:0] next_count;
	logic               next_busy;
	logic               next_done;

	always_comb begin
		next_count = count;
		next_busy  = busy_o;
		next_done  = 1'b0;
		if (start_i) begin
			next_count = (PSM_CNT_W+1)'(START_CYCLES - 1);
			next_busy  = 1'b1;
		end else if (busy_o) begin
			if (count == '0) begin
				next_busy = 1'b0;
				next_done = 1'b1; // [R19]
			end else begin
				next_count = count - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count  <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			count  <= next_count;
			busy_o <= next_busy;
			done_o <= next_done;
		end
	end

endmodule

/* File: tb/psm_core_model.sv */
// Core model: issues WAIT and STOP strobes from a chosen context.
// Assumes the bench calls enter() and drives every interrupt source itself.
module psm_core_model
	import psm_pkg::*;
(
	input  wire logic core_clk_i,
	output logic      wait_instr_o,
	output logic      stop_instr_o,
	output psm_ctx_t  core_ctx_o,
	output logic      aux_en_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		wait_instr_o = 1'b0;
		stop_instr_o = 1'b0;
		core_ctx_o = PSM_CTX_MAIN;
		aux_en_o = 1'b0;
	end

	// Aux enable lands one cycle ahead of the strobe, as software must do
	task automatic enter(input psm_ctx_t ctx, input logic stop, input logic aux);
		@(negedge core_clk_i);
		core_ctx_o = ctx;
		aux_en_o = aux;
		@(negedge core_clk_i);
		wait_instr_o = ~stop;
		stop_instr_o = stop;
		@(negedge core_clk_i);
		wait_instr_o = 1'b0;
		stop_instr_o = 1'b0;
	endtask
endmodule

/* File: tb/psm_ctrl_tb_top.sv */
// Testbench for the power-mode sequencer: one hand-written task per scenario.
// Assumes a 200 MHz clock, inputs driven on the falling edge, START_CYCLES of 8.
module psm_ctrl_tb_top
	import psm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int SC = 8;

	logic            core_clk;
	logic            rst;
	logic            wdog;
	logic            xopt;
	logic            nmi_pin;
	logic            nmi_req;
	logic            ext_irq;
	logic [7:0]      interrupt_option_reg;
	logic [3:0]      pirq;
	logic [3:0]      pext;
	logic            wait_s;
	logic            stop_s;
	logic            aux;
	psm_ctx_t        ctx;
	psm_mode_t       mode;
	logic            cpu_en;
	logic            per_en;
	logic            osc_en;
	logic            aux_on;
	logic            frz;
	psm_resume_cmd_t res;
	int              num_errors;
	int              compares;
	int              n;
	wire logic [7:0] ens = {3'h0, cpu_en, per_en, osc_en, aux_on, frz};

	psm_core_model u_psm_core_model (
		.core_clk_i   (core_clk),
		.wait_instr_o (wait_s),
		.stop_instr_o (stop_s),
		.core_ctx_o   (ctx),
		.aux_en_o     (aux)
	);

	psm_ctrl #(.START_CYCLES(SC)) u_psm_ctrl (
		.core_clk_i                  (core_clk),
		.rst_i                       (rst),
		.wait_instr_i                (wait_s),
		.stop_instr_i                (stop_s),
		.core_ctx_i                  (ctx),
		.interrupt_option_reg_i      (interrupt_option_reg),
		.low_freq_aux_osc_i          (aux),
		.watchdog_active_i           (wdog),
		.stop_external_control_opt_i (xopt),
		.nmi_pin_i                   (nmi_pin),
		.nmi_req_i                   (nmi_req),
		.ext_irq_i                   (ext_irq),
		.periph_irq_i                (pirq),
		.periph_ext_clk_i            (pext),
		.mode_o                      (mode),
		.cpu_clk_en_o                (cpu_en),
		.periph_clk_en_o             (per_en),
		.main_osc_en_o               (osc_en),
		.aux_osc_en_o                (aux_on),
		.watchdog_freeze_o           (frz),
		.resume_o                    (res)
	);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmode(input psm_mode_t e);
		chk("mode", 8'(e), 8'(mode));
	endtask

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic idle(input int c);
		repeat (c) @(negedge core_clk);
	endtask

	// Bounded wait for the resume pulse; n is the falling edge count since the call
	task automatic await_res(input int lim);
		n = 0;
		for (int i = 1; i <= lim && n == 0; i++) begin
			@(negedge core_clk);
			if (res.valid === 1'b1) n = i;
		end
		if (n == 0) begin
			num_errors++;
			$display("Error resume_valid expected 1 seen 0");
			close_out();
		end
	endtask

	task automatic drop;
		ext_irq = 1'b0;
		nmi_req = 1'b0;
		pirq = 4'h0;
	endtask

	task automatic t_wait;
		for (int a = 0; a < 2; a++) begin
			u_psm_core_model.enter(PSM_CTX_MAIN, 1'b0, a[0]);
			cmode(PSM_MODE_WAIT);
			chk("wait_enables", a ? 8'h0a : 8'h0c, ens);
			idle(4);
			cmode(PSM_MODE_WAIT);
			pirq = 4'h4;
			await_res(6);
			chk("resume_kind", 8'(PSM_RES_SERVICE), 8'(res.kind));
			chk("cpu_clk_en", 8'h1, 8'(cpu_en));
			drop();
		end
		$display("wait entry and wake done");
	endtask

	task automatic t_stop;
		pext = 4'h2;
		u_psm_core_model.enter(PSM_CTX_NMI, 1'b1, 1'b0);
		cmode(PSM_MODE_STOP);
		chk("stop_enables", 8'h00, ens);
		pirq = 4'h1;
		idle(5);
		cmode(PSM_MODE_STOP);
		pirq = 4'h0;
		ext_irq = 1'b1;
		await_res(SC + 8);
		// Resume comes SC+2 edges after the wake edge; n counts from the wake edge itself
		chk("start_delay", 8'(SC + 3), 8'(n));
		chk("resume_kind", 8'(PSM_RES_NEXT), 8'(res.kind));
		drop();
		u_psm_core_model.enter(PSM_CTX_MAIN, 1'b1, 1'b0);
		pirq = 4'h2;
		await_res(SC + 8);
		chk("start_delay", 8'(SC + 3), 8'(n));
		chk("resume_kind", 8'(PSM_RES_SERVICE), 8'(res.kind));
		drop();
		pext = 4'h0;
		$display("stop entry and wake done");
	endtask

	task automatic t_gen_off;
		interrupt_option_reg = 8'h00;
		u_psm_core_model.enter(PSM_CTX_MAIN, 1'b0, 1'b0);
		nmi_req = 1'b1;
		idle(5);
		cmode(PSM_MODE_WAIT);
		nmi_req = 1'b0;
		ext_irq = 1'b1;
		pirq = 4'hf;
		idle(5);
		cmode(PSM_MODE_WAIT);
		ext_irq = 1'b0;
		pirq = 4'h0;
		interrupt_option_reg = 8'h10;
		nmi_req = 1'b1;
		await_res(6);
		chk("resume_kind", 8'(PSM_RES_SERVICE), 8'(res.kind));
		drop();
		$display("global enable masking done");
	endtask

	task automatic t_pending;
		idle(1);
		ext_irq = 1'b1;
		u_psm_core_model.enter(PSM_CTX_MAIN, 1'b0, 1'b0);
		cmode(PSM_MODE_RUN);
		u_psm_core_model.enter(PSM_CTX_MAIN, 1'b1, 1'b0);
		cmode(PSM_MODE_RUN);
		chk("run_enables", 8'h1c, ens);
		drop();
		$display("pending refusal done");
	endtask

	task automatic t_irq_ctx;
		u_psm_core_model.enter(PSM_CTX_IRQ, 1'b0, 1'b0);
		pirq = 4'h8;
		await_res(6);
		chk("resume_kind", 8'(PSM_RES_NEXT), 8'(res.kind));
		drop();
		u_psm_core_model.enter(PSM_CTX_IRQ, 1'b0, 1'b0);
		nmi_req = 1'b1;
		await_res(6);
		chk("resume_kind", 8'(PSM_RES_NMI_FIRST), 8'(res.kind));
		drop();
		$display("interrupt context resume done");
	endtask

	// Real STOP under the watchdog needs the synchronised pin, so it settles first
	task automatic t_wdog;
		wdog = 1'b1;
		u_psm_core_model.enter(PSM_CTX_MAIN, 1'b1, 1'b0);
		cmode(PSM_MODE_WAIT);
		chk("wdog_wait_enables", 8'h0c, ens);
		ext_irq = 1'b1;
		await_res(6);
		drop();
		xopt = 1'b1;
		nmi_pin = 1'b1;
		u_psm_core_model.enter(PSM_CTX_MAIN, 1'b1, 1'b0);
		cmode(PSM_MODE_STOP);
		chk("frozen_enables", 8'h01, ens);
		idle(2);
		rst = 1'b1;
		idle(1);
		rst = 1'b0;
		idle(1);
		cmode(PSM_MODE_RUN);
		chk("reset_enables", 8'h1c, ens);
		wdog = 1'b0;
		xopt = 1'b0;
		nmi_pin = 1'b0;
		$display("watchdog and reset done");
	endtask

	initial begin
		num_errors = 0;
		compares = 0;
		n = 0;
		rst = 1'b1;
		wdog = 1'b0;
		xopt = 1'b0;
		nmi_pin = 1'b0;
		interrupt_option_reg = 8'h10;
		pext = 4'h0;
		drop();
		idle(20);
		rst = 1'b0;
		idle(1);
		cmode(PSM_MODE_RUN);
		chk("reset_enables", 8'h1c, ens);
		$display("reset state done");
		t_wait();
		t_stop();
		t_gen_off();
		t_pending();
		t_irq_ctx();
		t_wdog();
		close_out();
	end
endmodule
